// ===== core/aicsts_pkg.sv
// Shared constants for the analog input code and status block
package aicsts_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CH_MAX = 8;
  localparam int CODE_W = 14;
  localparam int RAW_W = 13;
  // Channel codes
  localparam logic [13:0] CODE_INVALID_LO = 14'h0000;
  localparam logic [13:0] CODE_MIN = 14'h0001;
  localparam logic [13:0] CODE_MID = 14'h1000;
  localparam logic [13:0] CODE_MAX = 14'h1FFF;
  localparam logic [13:0] CODE_INVALID_HI = 14'h2000;
  // Times in milliseconds
  localparam int T_HOLD_MS = 3000;
  localparam int T_UPD4_MS = 400;
  localparam int T_UPD8_MS = 710;
  localparam int T_OOR_MS = 220;
  localparam int T_BLINK_MS = 250;
  localparam int T_COMM_MS = 100;
  localparam int MS_CYC = CLK_HZ / 1000;
  // Register map (word index = byte address / 4)
  localparam logic [7:0] REG_CH0 = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_MASK = 8'h24;
  localparam logic [7:0] REG_CTRL = 8'h28;
  localparam logic [7:0] REG_LIVE = 8'h2C;
  // Control fields
  localparam int CTRL_EIGHT = 0;
  localparam int CTRL_PLC_RUN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // Status event bits
  localparam int EV_UPDATE = 0;
  localparam int EV_OOR = 1;
  localparam int EV_DIAG = 2;
  localparam int EV_READY = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Live state bits
  localparam int LV_HOLD = 0;
  localparam int LV_ACT = 1;
  localparam int LV_OVR = 2;
  localparam int LV_REF_BAD = 3;
  localparam int LV_DIAG_BAD = 4;
endpackage

// ===== core/aicsts_core.sv
// Channel code formation, power-up sequence, indicators and register port
// How it works
// - valid conversion gives code proportional to input, from 1 to 8191
// - codes 0 and 8192 only mark invalid data
// - zero volts or open input gives mid-scale code 4096
// - at power-up run diagnostics, clear latches, show zero on all words
// - hold zero about three seconds, then start scheduled conversion
// - four or eight channels, same behaviour otherwise
// - run/reset switch in reset keeps the device inactive
// - activity lamp steady while link works and controller runs
// - activity lamp blinks after a failed power-up reference test
// - with reference test passed, activity lamp off on diagnostic fail, controller stop, link loss
// - shared over-range lamp off when all in range, on otherwise
// - eight channels occupy eight consecutive words, word indices 0 to 7
// - pass every 400 or 710 ms, plus 220 ms per out-of-range channel
// - run-time diagnostic failure returns code zero
`timescale 1ns/1ps
module aicsts_core #(
  parameter int HOLD_CYC = aicsts_pkg::T_HOLD_MS * aicsts_pkg::MS_CYC,
  parameter int MS_TICK = aicsts_pkg::MS_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Run/reset switch pin (asynchronous)
  input wire logic run_sw,
  // Converter results per channel
  input wire logic [12:0] raw_code [8],
  input wire logic [7:0] raw_under,
  input wire logic [7:0] raw_over,
  // Diagnostics
  input wire logic ref_fail,
  input wire logic diag_fail,
  input wire logic diag_done,
  // Controller link activity, one-cycle pulse per good frame
  input wire logic link_ok,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Indicators and interrupt
  output logic active_led,
  output logic over_led,
  output logic irq
);
  typedef enum logic [1:0] {ST_HOLD, ST_RUN} aicsts_state_t;

  // Switch synchroniser: change taken when second and third stage agree
  logic [2:0] sw_sync_q;
  logic sw_run_q, sw_run_d;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sw_sync_q <= 3'h0;
      sw_run_q <= 1'b0;
    end else if (ce) begin
      sw_sync_q <= {sw_sync_q[1:0], run_sw};
      sw_run_q <= sw_run_d;
    end
  end
  assign sw_run_d = (sw_sync_q[2] == sw_sync_q[1]) ? sw_sync_q[2] : sw_run_q;
  wire active_rst = !rst_b || !sw_run_q;

  // Registers
  logic [1:0] ctrl_q;
  logic [3:0] mask_q, status_q;
  logic [13:0] word_q [8];
  logic [7:0] oor_q;
  logic ref_bad_q, diag_bad_q;
  aicsts_state_t st_q;
  logic [31:0] hold_q, pass_q, ms_q, blink_q, comm_q;
  logic blink_ph_q, comm_ok_q;
  logic [31:0] rdata_q;

  function automatic logic [13:0] form_code(input logic [12:0] raw,
      input logic und, input logic ovr);
    if (ovr)
      form_code = aicsts_pkg::CODE_INVALID_HI;
    else if (und)
      form_code = aicsts_pkg::CODE_INVALID_LO;
    else if (raw == 13'h0000)
      form_code = aicsts_pkg::CODE_MIN;
    else
      form_code = {1'b0, raw};
  endfunction

  wire eight = ctrl_q[aicsts_pkg::CTRL_EIGHT];
  wire [7:0] ch_en = eight ? 8'hFF : 8'h0F;
  wire [7:0] oor_now = (raw_under | raw_over) & ch_en;
  logic [3:0] oor_cnt;
  always_comb begin
    oor_cnt = 4'h0;
    for (int i = 0; i < aicsts_pkg::CH_MAX; i++)
      oor_cnt = oor_cnt + {3'h0, oor_q[i]};
  end
  wire ms_tick = (ms_q == 32'(MS_TICK - 1));
  wire [31:0] base_ms = eight ? 32'(aicsts_pkg::T_UPD8_MS)
                              : 32'(aicsts_pkg::T_UPD4_MS);
  wire [31:0] pass_ms = base_ms
      + 32'(oor_cnt) * 32'(aicsts_pkg::T_OOR_MS);
  wire pass_done = (st_q == ST_RUN) && ms_tick
      && (pass_q >= pass_ms - 32'h1);
  wire hold_done = (st_q == ST_HOLD) && (hold_q == 32'(HOLD_CYC - 1))
      && diag_done;
  wire plc_run = ctrl_q[aicsts_pkg::CTRL_PLC_RUN];

  // Millisecond tick, free running once the sequence is released
  always_ff @(posedge clk) begin
    if (active_rst) begin
      ms_q <= 32'h0;
    end else if (ce) begin
      ms_q <= ms_tick ? 32'h0 : ms_q + 32'h1;
    end
  end

  // Power-up hold, then scheduled passes
  always_ff @(posedge clk) begin
    if (active_rst) begin
      st_q <= ST_HOLD;
      hold_q <= 32'h0;
    end else if (ce) begin
      unique case (st_q)
        ST_HOLD: begin
          if (hold_q != 32'(HOLD_CYC - 1))
            hold_q <= hold_q + 32'h1;
          if (hold_done)
            st_q <= ST_RUN;
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_HOLD;
      endcase
    end
  end

  // Pass timer counts the milliseconds of the running pass
  always_ff @(posedge clk) begin
    if (active_rst) begin
      pass_q <= 32'h0;
    end else if (ce && st_q == ST_RUN && ms_tick) begin
      pass_q <= pass_done ? 32'h0 : pass_q + 32'h1;
    end
  end

  // Out-of-range set latched at a pass end sizes the next pass
  always_ff @(posedge clk) begin
    if (active_rst) begin
      oor_q <= 8'h0;
    end else if (ce && pass_done) begin
      oor_q <= oor_now;
    end
  end

  // Fault flags; the reference test only counts during the hold
  always_ff @(posedge clk) begin
    if (active_rst) begin
      ref_bad_q <= 1'b0;
      diag_bad_q <= 1'b0;
    end else if (ce) begin
      if (ref_fail && st_q == ST_HOLD)
        ref_bad_q <= 1'b1;
      if (diag_fail)
        diag_bad_q <= 1'b1;
    end
  end

  // Channel words change only at a pass end, so a poll never sees
  // a half-formed code
  wire [7:0] word_zero = {8{diag_bad_q || diag_fail}} | ~ch_en;
  logic [13:0] word_d [8];
  for (genvar g = 0; g < aicsts_pkg::CH_MAX; g++) begin : g_word
    assign word_d[g] = word_zero[g] ? aicsts_pkg::CODE_INVALID_LO
        : form_code(raw_code[g], raw_under[g], raw_over[g]);
  end
  always_ff @(posedge clk) begin
    if (active_rst) begin
      for (int i = 0; i < aicsts_pkg::CH_MAX; i++)
        word_q[i] <= aicsts_pkg::CODE_INVALID_LO;
    end else if (ce && pass_done) begin
      word_q <= word_d;
    end
  end

  // Link watchdog: every good frame restarts the timeout
  always_ff @(posedge clk) begin
    if (active_rst) begin
      comm_q <= 32'h0;
      comm_ok_q <= 1'b0;
    end else if (ce) begin
      if (link_ok) begin
        comm_q <= 32'h0;
        comm_ok_q <= 1'b1;
      end else if (ms_tick) begin
        if (comm_q == 32'(aicsts_pkg::T_COMM_MS - 1))
          comm_ok_q <= 1'b0;
        else
          comm_q <= comm_q + 32'h1;
      end
    end
  end

  // Blink phase for a failed reference test
  wire blink_end = (blink_q == 32'(aicsts_pkg::T_BLINK_MS - 1));
  always_ff @(posedge clk) begin
    if (active_rst) begin
      blink_q <= 32'h0;
      blink_ph_q <= 1'b0;
    end else if (ce && ms_tick) begin
      blink_q <= blink_end ? 32'h0 : blink_q + 32'h1;
      if (blink_end)
        blink_ph_q <= !blink_ph_q;
    end
  end

  // Indicators
  wire act_d = ref_bad_q ? blink_ph_q
      : (!diag_bad_q && plc_run && comm_ok_q
         && st_q == ST_RUN);
  wire ovr_d = |oor_q;
  always_ff @(posedge clk) begin
    if (active_rst) begin
      active_led <= 1'b0;
      over_led <= 1'b0;
    end else if (ce) begin
      active_led <= act_d;
      over_led <= ovr_d;
    end
  end

  // Register port: channel words at consecutive indices 0..7
  function automatic logic at_reg(input logic [7:0] addr,
      input logic [7:0] off);
    at_reg = (addr == off);
  endfunction
  // Events: pass done, pass with out-of-range, new fault, hold over
  wire [3:0] ev = {hold_done, diag_fail && !diag_bad_q,
                   pass_done && |oor_now, pass_done};
  wire rd_ch = reg_rd && reg_addr < aicsts_pkg::REG_STATUS
      && reg_addr[1:0] == 2'h0;
  wire [2:0] ch_idx = reg_addr[4:2];
  wire rd_status = reg_rd && at_reg(reg_addr, aicsts_pkg::REG_STATUS);
  wire wr_ctrl = reg_wr && at_reg(reg_addr, aicsts_pkg::REG_CTRL);
  wire wr_mask = reg_wr && at_reg(reg_addr, aicsts_pkg::REG_MASK);
  // A fault zeroes channel reads at once, not only at the next pass
  wire ch_zero = diag_bad_q || diag_fail;
  wire [4:0] live = {diag_bad_q, ref_bad_q, over_led, active_led,
                     st_q == ST_HOLD};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (rd_ch)
      rd_mux = ch_zero ? 32'h0 : {18'h0, word_q[ch_idx]};
    else if (at_reg(reg_addr, aicsts_pkg::REG_STATUS))
      rd_mux = {28'h0, status_q};
    else if (at_reg(reg_addr, aicsts_pkg::REG_MASK))
      rd_mux = {28'h0, mask_q};
    else if (at_reg(reg_addr, aicsts_pkg::REG_CTRL))
      rd_mux = {30'h0, ctrl_q};
    else if (at_reg(reg_addr, aicsts_pkg::REG_LIVE))
      rd_mux = {27'h0, live};
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= aicsts_pkg::CTRL_RST;
    end else if (ce && wr_ctrl) begin
      ctrl_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_q <= aicsts_pkg::MASK_RST;
    end else if (ce && wr_mask) begin
      mask_q <= reg_wdata[3:0];
    end
  end

  // Status: a set wins over the read-clear, so no event is lost
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= 4'h0;
    end else if (ce) begin
      status_q <= (rd_status ? 4'h0 : status_q)
          | (sw_run_q ? ev : 4'h0);
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = rdata_q;
  assign irq = |(status_q & mask_q);
endmodule

// ===== dv/aicsts_core_props.sv
// Port-level checks for the analog input core
`timescale 1ns/1ps
module aicsts_core_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire logic run_sw,
  input wire logic diag_fail,
  input wire logic [7:0] raw_under,
  input wire logic [7:0] raw_over,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [31:0] reg_rdata,
  input wire logic active_led,
  input wire logic over_led,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RD_ONE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_CODE: assert property ($past(reg_rd) && $past(reg_addr) < 8'h20 |->
    reg_rdata[31:14] == 18'h0 && (!reg_rdata[13] || reg_rdata[12:0] == 0))
    else $error("channel code out of set");
  AST_SW: assert property (!run_sw [*5] |=> !active_led && !over_led)
    else $error("lamps lit in reset position");
  AST_DIAG_CODE: assert property (diag_fail [*8] ##0 reg_rd &&
    reg_addr < 8'h20 |=> reg_rdata == 32'h0)
    else $error("nonzero code on diagnostic fail");
  AST_DIAG_LED: assert property (diag_fail [*8] |-> !active_led)
    else $error("activity lamp on with diagnostic fail");
  AST_OVER: assert property ($rose(over_led) |->
    ($past(raw_over) | $past(raw_under)) != 8'h00)
    else $error("over lamp without out-of-range input");
  AST_ACT: assert property ($rose(active_led) |->
    $past(run_sw, 3) && !diag_fail)
    else $error("activity lamp rose while inactive");
  AST_IRQ: assert property (reg_wr && reg_addr == 8'h24 &&
    reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt with all events masked");
endmodule

// ===== dv/aicsts_ctrl_model.sv
// Controller model: sends good frames while enabled
`timescale 1ns/1ps
module aicsts_ctrl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic en,
  // Link
  output logic link_ok
);
  logic [3:0] cnt_q;
  // One poll each 16 cycles, well inside the link loss timeout
  always_ff @(posedge clk) begin
    if (!rst_b) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  assign link_ok = en && cnt_q == 4'hF;
endmodule

// ===== dv/aicsts_core_tb_top.sv
// Self-checking bench for the analog input core
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module aicsts_core_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, run_sw = 1'b1;
  logic [12:0] raw_code [8] = '{default: 13'h0000};
  logic [7:0] raw_under = 8'h00, raw_over = 8'h00, reg_addr = 8'h00;
  logic ref_fail = 1'b0, diag_fail = 1'b0, diag_done = 1'b1;
  logic link_en = 1'b1, link_ok, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
  logic active_led, over_led, irq;
  int n_errors = 0, comparisons = 0, cyc = 0, t0;
  always #12.5 clk = ~clk;
  aicsts_ctrl_model ctrl (.clk(clk), .rst_b(rst_b), .en(link_en),
    .link_ok(link_ok));
  aicsts_core #(.HOLD_CYC(100), .MS_TICK(4)) dut (.clk(clk),
    .rst_b(rst_b), .ce(ce), .run_sw(run_sw), .raw_code(raw_code),
    .raw_under(raw_under), .raw_over(raw_over), .ref_fail(ref_fail),
    .diag_fail(diag_fail), .diag_done(diag_done), .link_ok(link_ok),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_led(active_led),
    .over_led(over_led), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  // Polling clears status, so each pass is seen exactly once
  task automatic wait_pass;
    for (int i = 0; i < 4000; i++) begin
      rd(8'h20);
      if (rdv[0] === 1'b1) break;
    end
    `CHK("pass", 1'b1, rdv[0])
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic t_power;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      `CHK("hold code", 32'h0, rdv)
    end
    wr(8'h24, 32'h8);
    repeat (100) @(posedge clk);
    #1 `CHK("irq", 1'b1, irq)
    rd(8'h20);
    `CHK("ready", 1'b1, rdv[3])
    rd(8'h00);
    `CHK("zero after hold", 32'h0, rdv)
    wr(8'h24, 32'h0);
    $display("test power done");
  endtask
  task automatic t_codes;
    raw_code[0] <= 13'h1800;
    raw_code[2] <= 13'h1000;
    raw_over <= 8'h08;
    raw_under <= 8'h10;
    wait_pass;
    t0 = cyc;
    raw_over <= 8'h00;
    raw_under <= 8'h00;
    rd(8'h00);
    `CHK("ch0", 32'h1800, rdv)
    rd(8'h04);
    `CHK("ch1", 32'h1, rdv)
    rd(8'h08);
    `CHK("ch2", 32'h1000, rdv)
    rd(8'h0C);
    `CHK("ch3", 32'h2000, rdv)
    rd(8'h10);
    `CHK("ch4", 32'h0, rdv)
    `CHK("over on", 1'b1, over_led)
    `CHK("active", 1'b1, active_led)
    wait_pass;
    `CHK("oor len", 1'b1, cyc - t0 > 4590 && cyc - t0 < 4610)
    `CHK("over off", 1'b0, over_led)
    $display("test codes done");
  endtask
  task automatic t_four;
    wr(8'h28, 32'h2);
    wait_pass;
    t0 = cyc;
    wait_pass;
    `CHK("four len", 1'b1, cyc - t0 > 1590 && cyc - t0 < 1610)
    rd(8'h14);
    `CHK("ch5 off", 32'h0, rdv)
    rd(8'h00);
    `CHK("ch0 kept", 32'h1800, rdv)
    wr(8'h28, 32'h3);
    $display("test four done");
  endtask
  task automatic t_diag;
    link_en <= 1'b0;
    repeat (450) @(posedge clk);
    #1 `CHK("link lost", 1'b0, active_led)
    link_en <= 1'b1;
    diag_fail <= 1'b1;
    repeat (40) @(posedge clk);
    rd(8'h00);
    `CHK("diag code", 32'h0, rdv)
    `CHK("diag led", 1'b0, active_led)
    run_sw <= 1'b0;
    repeat (10) @(posedge clk);
    #1 `CHK("sw led", 1'b0, active_led)
    {diag_fail, ref_fail, run_sw} <= 3'b011;
    do_reset;
    repeat (120) @(posedge clk);
    rd(8'h2C);
    `CHK("ref bad", 1'b1, rdv[3])
    repeat (1000) @(posedge clk);
    #1 `CHK("blink", 1'b1, active_led)
    $display("test diag done");
  endtask
  task automatic final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    do_reset;
    t_power;
    t_codes;
    t_four;
    t_diag;
    final_report;
  end
endmodule
bind aicsts_core aicsts_core_props props (.clk(clk), .rst_b(rst_b),
  .run_sw(run_sw), .diag_fail(diag_fail), .raw_under(raw_under),
  .raw_over(raw_over), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .active_led(active_led), .over_led(over_led), .irq(irq));
